// >>> dpe_pkg.sv
// Constants, tables and shared helpers for the two-path playback equaliser,
// stereo-width and record volume block.
// Assumes one 250 MHz clock and samples paced by one-cycle valid strobes.
//
// How it works
// - Default equaliser: five bands at 100, 300, 875, 2400, 6900 Hz, fixed widths.
// - Each path's band frequencies follow that path's own sample rate.
// - Five-bit band gain, -12 to +12 dB in 1 dB steps, resets to 0 dB.
// - Gain codes linear from 00000 (-12 dB) to 11000 (+12 dB); above reserved.
// - Bands 1-3 in bits 15:11, 10:6, 5:1; bands 4-5 in 15:11, 10:6.
// - User mode takes frequency and width from coefficients; enable and gains unchanged.
// - Coefficients held at 1154-1171 for path one, 1410-1427 for path two.
// - Bands 1 and 5 are shelves, bands 2 to 4 are peaks.
// - Stereo width feeds adjustable cross-talk between left and right.
// - Depth code 0 is off, 1 is -16 dB, 0.915 dB steps, 31 is +11.5 dB.
// - Width enable bit 8 resets to 0; depth in bits 13:9.
// - Volume code: 0 mutes, 0.375*(X-192) dB, 239 upward is +17.625 dB.
// - Volume write without update bit stores but does not apply.
// - Update bit 8 of either volume register applies both gains together.
// - Volume field bits 7:0 resets to C0h, 0 dB.
// - Equaliser enable is bit 0 of first gain register, resets to 0.
// - Fixed frequencies hold at 48 kHz and scale with other rates.

package dpe_pkg;

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [1:0][10:0] IDX_TX_LEFT = {11'h500, 11'h400};
	localparam logic [1:0][10:0] IDX_TX_RIGHT = {11'h501, 11'h401};
	localparam logic [1:0][10:0] IDX_WIDTH = {11'h521, 11'h421};
	localparam logic [1:0][10:0] IDX_EQ_FIRST = {11'h580, 11'h480};
	localparam logic [1:0][10:0] IDX_EQ_SECOND = {11'h581, 11'h481};
	localparam logic [1:0][10:0] IDX_COEF_BASE = {11'h582, 11'h482};
	localparam logic [1:0][10:0] IDX_MODE = {11'h5a0, 11'h4a0};
	localparam logic [4:0] NUM_COEF = 5'h12;

	// ==========================================================
	// Field positions, masks and reset values
	localparam int EQ_ON_BIT = 0;
	localparam int BAND_LSB [5] = '{11, 6, 1, 11, 6};
	localparam int WIDTH_ON_BIT = 8;
	localparam int DEPTH_LSB = 9;
	localparam int COMMIT_BIT = 8;
	localparam int MODE_USER_BIT = 0;
	localparam logic [15:0] EQ_FIRST_RST = 16'h6318;
	localparam logic [15:0] EQ_SECOND_RST = 16'h6300;
	localparam logic [15:0] EQ_SECOND_MASK = 16'hffc0;
	localparam logic [15:0] WIDTH_MASK = 16'h3f00;
	localparam logic [15:0] MODE_MASK = 16'h0001;
	localparam logic [7:0] VOL_RST = 8'hc0;
	localparam logic [7:0] VOL_CLAMP = 8'hef;
	localparam logic [4:0] GAIN_ZERO_DB = 5'h0c;
	localparam logic [4:0] GAIN_MAX_CODE = 5'h18;
	localparam logic [16:0] GAIN_ONE = 17'h01000;

	// ==========================================================
	// Band kinds and default coefficients for 48 kHz
	localparam logic [1:0] KIND_LOW_SHELF = 2'h0;
	localparam logic [1:0] KIND_HIGH_SHELF = 2'h1;
	localparam logic [1:0] KIND_PEAK = 2'h2;
	localparam logic [1:0] BAND_KIND [5] = '{2'h0, 2'h2, 2'h2, 2'h2, 2'h1};
	localparam logic [15:0] DEF_FREQ [5] = '{16'h0354, 16'h09db, 16'h1bb4, 16'h4504, 16'h983e};
	localparam logic [15:0] DEF_WIDTH [5] = '{16'h0000, 16'h04fa, 16'h0e3c, 16'h2533, 16'h0000};

	// ==========================================================
	// Linear gain tables
	localparam logic [15:0] EQ_GAIN_TAB [25] = '{
		16'h0405, 16'h0483, 16'h050f, 16'h05ad, 16'h065f, 16'h0726, 16'h0805, 16'h08ff,
		16'h0a18, 16'h0b54, 16'h0cb6, 16'h0e43, 16'h1000, 16'h11f4, 16'h1424, 16'h169a,
		16'h195c, 16'h1c74, 16'h1fed, 16'h23d2, 16'h2831, 16'h2d18, 16'h3299, 16'h38c5,
		16'h3fb2};
	localparam logic [15:0] DEPTH_TAB [32] = '{
		16'h0000, 16'h0289, 16'h02d1, 16'h0321, 16'h037a, 16'h03dd, 16'h044b, 16'h04c5,
		16'h054d, 16'h05e4, 16'h068b, 16'h0745, 16'h0814, 16'h08fa, 16'h09f9, 16'h0b15,
		16'h0c50, 16'h0daf, 16'h0f34, 16'h10e4, 16'h12c5, 16'h14db, 16'h172c, 16'h19bf,
		16'h1c9c, 16'h1fca, 16'h2352, 16'h273f, 16'h2b9b, 16'h3074, 16'h35d6, 16'h3bd2};
	localparam logic [15:0] VOL_FRAC_TAB [16] = '{
		16'h4000, 16'h42d3, 16'h45c6, 16'h48db, 16'h4c11, 16'h4f6b, 16'h52ed, 16'h5696,
		16'h5a66, 16'h5e65, 16'h628d, 16'h66e8, 16'h6b71, 16'h702e, 16'h7522, 16'h7a4e};

	// ==========================================================
	// Helpers
	function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
		if (v > 48'sh000000007fff) begin
			return 16'sh7fff;
		end else if (v < -48'sh000000008000) begin
			return -16'sh8000;
		end
		return v[15:0];
	endfunction

endpackage

// >>> dpe_band.sv
// One equaliser band for one channel: shelf or peak built from one-pole sections.
// Output is combinational from the input sample and the held state; the state
// advances only on the path's sample strobe, so the band tracks the sample rate.

module dpe_band (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Sample strobe and settings
	input wire logic step,
	input wire logic [1:0] kind,
	input wire logic [15:0] coef_f,
	input wire logic [15:0] coef_b,
	input wire logic [15:0] gain_q,
	// Samples
	input wire logic signed [15:0] x,
	output logic signed [15:0] y
);

	typedef struct packed {
		logic signed [23:0] lp_hi;
		logic signed [23:0] lp_lo;
	} dpe_band_s;

	dpe_band_s q, d;
	logic signed [23:0] xs;
	logic signed [24:0] band;
	logic signed [41:0] p_hi, p_lo, boost;

	// ==========================================================
	// Filter state and band shaping
	always_comb begin
		d = q;
		xs = $signed({x, 8'h00});
		p_hi = 42'(25'(xs) - 25'(q.lp_hi)) * 42'($signed({1'b0, coef_f}));
		p_lo = 42'(25'(xs) - 25'(q.lp_lo)) * 42'($signed({1'b0, coef_b}));
		if (step) begin
			d.lp_hi = q.lp_hi + 24'(p_hi >>> 16);
			d.lp_lo = q.lp_lo + 24'(p_lo >>> 16);
		end
		// Low shelf lifts what lies under the corner, high shelf what lies above
		unique case (kind)
			dpe_pkg::KIND_LOW_SHELF: band = 25'(q.lp_hi);
			dpe_pkg::KIND_HIGH_SHELF: band = 25'(xs) - 25'(q.lp_hi);
			default: band = 25'(q.lp_hi) - 25'(q.lp_lo);
		endcase
		boost = 42'(band) * 42'($signed({1'b0, gain_q}) - $signed(dpe_pkg::GAIN_ONE));
		// At 0 dB the boost term is exactly zero, so a flat band is transparent
		y = dpe_pkg::sat16(48'(x) + 48'(boost >>> 20));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule

// >>> dpe_top.sv
// Two playback paths (five-band equaliser and stereo width) and two record
// paths (latched left/right volume), with their registers behind AXI4-Lite.
// Samples come from and go to audio interface logic on the same clock; each
// path's valid strobe marks one stereo sample at that path's own rate.

module dpe_top (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [15:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [15:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Playback samples in, index is the path
	input wire logic [1:0] rx_in_valid,
	input wire logic [1:0][15:0] rx_in_left,
	input wire logic [1:0][15:0] rx_in_right,
	// Playback samples out
	output logic [1:0] rx_out_valid,
	output logic [1:0][15:0] rx_out_left,
	output logic [1:0][15:0] rx_out_right,
	// Record samples in
	input wire logic [1:0] tx_in_valid,
	input wire logic [1:0][15:0] tx_in_left,
	input wire logic [1:0][15:0] tx_in_right,
	// Record samples out
	output logic [1:0] tx_out_valid,
	output logic [1:0][15:0] tx_out_left,
	output logic [1:0][15:0] tx_out_right
);

	localparam logic [2:0] SEL_TXL = 3'h0;
	localparam logic [2:0] SEL_TXR = 3'h1;
	localparam logic [2:0] SEL_WID = 3'h2;
	localparam logic [2:0] SEL_EQ1 = 3'h3;
	localparam logic [2:0] SEL_EQ2 = 3'h4;
	localparam logic [2:0] SEL_COEF = 3'h5;
	localparam logic [2:0] SEL_MODE = 3'h6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic hit;
		logic path;
		logic [2:0] sel;
		logic [4:0] cidx;
	} dpe_dec_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic rd_vol;
		logic aw_held;
		logic [15:0] aw_addr;
		logic w_held;
		logic [15:0] w_data;
		logic [1:0] w_strb;
		logic [1:0][15:0] eq_first;
		logic [1:0][15:0] eq_second;
		logic [1:0][15:0] width;
		logic [1:0] mode;
		logic [1:0][17:0][15:0] coef;
		logic [1:0][7:0] vol_left;
		logic [1:0][7:0] vol_right;
		logic [1:0][7:0] app_left;
		logic [1:0][7:0] app_right;
		logic [1:0] pending;
		logic [1:0] rx_valid;
		logic [1:0][15:0] rx_left;
		logic [1:0][15:0] rx_right;
		logic [1:0] tx_valid;
		logic [1:0][15:0] tx_left;
		logic [1:0][15:0] tx_right;
	} dpe_state_s;

	dpe_state_s q, d;

	// ==========================================================
	// Functions
	function automatic dpe_dec_s decode(input logic [15:0] addr);
		dpe_dec_s r;
		logic [10:0] idx;
		r = '0;
		idx = addr[12:2];
		if (addr[15:13] == 3'h0) begin
			for (int p = 0; p < 2; p++) begin
				r.path = (r.hit) ? r.path : 1'(p);
				if (idx == dpe_pkg::IDX_TX_LEFT[p]) begin
					r = '{1'b1, 1'(p), SEL_TXL, 5'h00};
				end else if (idx == dpe_pkg::IDX_TX_RIGHT[p]) begin
					r = '{1'b1, 1'(p), SEL_TXR, 5'h00};
				end else if (idx == dpe_pkg::IDX_WIDTH[p]) begin
					r = '{1'b1, 1'(p), SEL_WID, 5'h00};
				end else if (idx == dpe_pkg::IDX_EQ_FIRST[p]) begin
					r = '{1'b1, 1'(p), SEL_EQ1, 5'h00};
				end else if (idx == dpe_pkg::IDX_EQ_SECOND[p]) begin
					r = '{1'b1, 1'(p), SEL_EQ2, 5'h00};
				end else if (idx == dpe_pkg::IDX_MODE[p]) begin
					r = '{1'b1, 1'(p), SEL_MODE, 5'h00};
				end else if (idx >= dpe_pkg::IDX_COEF_BASE[p] &&
						idx < dpe_pkg::IDX_COEF_BASE[p] + 11'(dpe_pkg::NUM_COEF)) begin
					r = '{1'b1, 1'(p), SEL_COEF, 5'(idx - dpe_pkg::IDX_COEF_BASE[p])};
				end
			end
		end
		return r;
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
			input logic [1:0] strb);
		return {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
	endfunction

	// Reserved codes fall back to unity rather than an undefined gain
	function automatic logic [15:0] band_gain(input logic [4:0] code);
		return (code > dpe_pkg::GAIN_MAX_CODE) ? dpe_pkg::EQ_GAIN_TAB[dpe_pkg::GAIN_ZERO_DB] :
			dpe_pkg::EQ_GAIN_TAB[code];
	endfunction

	// Gain splits into whole 6 dB shifts and a sixteen-entry fraction; the
	// shift approximates 6.02 dB by 6 dB, an error of under 0.4 %
	function automatic logic signed [15:0] vol_apply(input logic signed [15:0] x,
			input logic [7:0] code);
		logic [7:0] c;
		logic signed [8:0] e;
		logic [4:0] rs;
		logic signed [47:0] p;
		c = (code > dpe_pkg::VOL_CLAMP) ? dpe_pkg::VOL_CLAMP : code;
		e = $signed({1'b0, c}) - 9'sh0c0;
		rs = 5'(9'sh00e - (e >>> 4));
		p = 48'(x) * 48'($signed({1'b0, dpe_pkg::VOL_FRAC_TAB[e[3:0]]}));
		if (code == 8'h00) begin
			return 16'sh0000;
		end
		return dpe_pkg::sat16(p >>> rs);
	endfunction

	// Cross-talk: each side gains k times its difference from the other
	function automatic logic [31:0] width_mix(input logic signed [15:0] l,
			input logic signed [15:0] r, input logic [15:0] k);
		logic signed [47:0] dif;
		logic signed [47:0] m;
		dif = 48'(l) - 48'(r);
		m = (dif * 48'($signed({1'b0, k}))) >>> 12;
		return {dpe_pkg::sat16(48'(l) + m), dpe_pkg::sat16(48'(r) - m)};
	endfunction

	// ==========================================================
	// Equaliser band chains, index [path][channel][band]
	logic [1:0][1:0][5:0][15:0] chain;

	for (genvar p = 0; p < 2; p++) begin : g_path
		for (genvar ch = 0; ch < 2; ch++) begin : g_chan
			assign chain[p][ch][0] = ch == 0 ? rx_in_left[p] : rx_in_right[p];
			for (genvar b = 0; b < 5; b++) begin : g_band
				logic [4:0] code;
				logic [15:0] cf, cb;
				logic signed [15:0] yb;
				if (b < 3) begin : g_first
					assign code = q.eq_first[p][dpe_pkg::BAND_LSB[b] +: 5];
				end else begin : g_second
					assign code = q.eq_second[p][dpe_pkg::BAND_LSB[b] +: 5];
				end
				assign cf = q.mode[p] ? q.coef[p][2 * b] : dpe_pkg::DEF_FREQ[b];
				assign cb = q.mode[p] ? q.coef[p][2 * b + 1] : dpe_pkg::DEF_WIDTH[b];
				assign chain[p][ch][b + 1] = yb;
				dpe_band u_band (
					.aclk(aclk),
					.aresetn(aresetn),
					.step(rx_in_valid[p]),
					.kind(dpe_pkg::BAND_KIND[b]),
					.coef_f(cf),
					.coef_b(cb),
					.gain_q(band_gain(code)),
					.x(chain[p][ch][b]),
					.y(yb)
				);
			end
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		dpe_dec_s wdec;
		dpe_dec_s rdec;
		logic [15:0] wr;
		logic [15:0] l, r;
		logic [7:0] gl, gr;
		logic [31:0] mix;
		logic [4:0] dep;
		d = q;
		wdec = decode(q.aw_addr);
		rdec = decode(araddr);
		wr = '0;
		l = '0;
		r = '0;
		gl = '0;
		gr = '0;
		mix = '0;
		dep = '0;

		// Record paths: a pending commit loads both gains before this sample
		for (int p = 0; p < 2; p++) begin
			d.tx_valid[p] = tx_in_valid[p];
			if (tx_in_valid[p]) begin
				gl = q.pending[p] ? q.vol_left[p] : q.app_left[p];
				gr = q.pending[p] ? q.vol_right[p] : q.app_right[p];
				d.tx_left[p] = vol_apply(tx_in_left[p], gl);
				d.tx_right[p] = vol_apply(tx_in_right[p], gr);
				d.app_left[p] = gl;
				d.app_right[p] = gr;
				d.pending[p] = 1'b0;
			end
		end

		// Playback paths
		for (int p = 0; p < 2; p++) begin
			d.rx_valid[p] = rx_in_valid[p];
			if (rx_in_valid[p]) begin
				l = q.eq_first[p][dpe_pkg::EQ_ON_BIT] ? chain[p][0][5] : rx_in_left[p];
				r = q.eq_first[p][dpe_pkg::EQ_ON_BIT] ? chain[p][1][5] : rx_in_right[p];
				dep = q.width[p][dpe_pkg::DEPTH_LSB +: 5];
				mix = width_mix(l, r, dpe_pkg::DEPTH_TAB[dep]);
				if (q.width[p][dpe_pkg::WIDTH_ON_BIT] && dep != 5'h00) begin
					l = mix[31:16];
					r = mix[15:0];
				end
				d.rx_left[p] = l;
				d.rx_right[p] = r;
			end
		end

		// Write channel: address and data are taken in either order
		if (q.awready && awvalid) begin
			d.aw_held = 1'b1;
			d.aw_addr = awaddr;
		end
		if (q.wready && wvalid) begin
			d.w_held = 1'b1;
			d.w_data = wdata[15:0];
			d.w_strb = wstrb[1:0];
		end
		if (q.bvalid && bready) begin
			d.bvalid = 1'b0;
		end
		if (q.aw_held && q.w_held && !q.bvalid) begin
			d.aw_held = 1'b0;
			d.w_held = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = wdec.hit ? RESP_OKAY : RESP_SLVERR;
			if (wdec.hit) begin
				unique case (wdec.sel)
					SEL_TXL: begin
						wr = merge({8'h00, q.vol_left[wdec.path]}, q.w_data, q.w_strb);
						d.vol_left[wdec.path] = wr[7:0];
					end
					SEL_TXR: begin
						wr = merge({8'h00, q.vol_right[wdec.path]}, q.w_data, q.w_strb);
						d.vol_right[wdec.path] = wr[7:0];
					end
					SEL_WID: begin
						wr = merge(q.width[wdec.path], q.w_data, q.w_strb);
						d.width[wdec.path] = wr & dpe_pkg::WIDTH_MASK;
					end
					SEL_EQ1: d.eq_first[wdec.path] = merge(q.eq_first[wdec.path], q.w_data, q.w_strb);
					SEL_EQ2: begin
						wr = merge(q.eq_second[wdec.path], q.w_data, q.w_strb);
						d.eq_second[wdec.path] = wr & dpe_pkg::EQ_SECOND_MASK;
					end
					SEL_COEF: begin
						d.coef[wdec.path][wdec.cidx] = merge(q.coef[wdec.path][wdec.cidx],
							q.w_data, q.w_strb);
					end
					default: begin
						wr = merge({15'h0000, q.mode[wdec.path]}, q.w_data, q.w_strb);
						d.mode[wdec.path] = wr[dpe_pkg::MODE_USER_BIT];
					end
				endcase
				// Commit is a strobe only; it wins over a sample loading the same cycle
				if ((wdec.sel == SEL_TXL || wdec.sel == SEL_TXR) && q.w_strb[1] &&
						q.w_data[dpe_pkg::COMMIT_BIT]) begin
					d.pending[wdec.path] = 1'b1;
				end
			end
		end
		d.awready = !d.aw_held && !d.bvalid;
		d.wready = !d.w_held && !d.bvalid;

		// Read channel: one cycle from address to data
		if (q.rvalid && rready) begin
			d.rvalid = 1'b0;
			d.arready = 1'b1;
		end
		if (q.arready && arvalid) begin
			d.arready = 1'b0;
			d.rvalid = 1'b1;
			d.rresp = rdec.hit ? RESP_OKAY : RESP_SLVERR;
			d.rd_vol = rdec.hit && (rdec.sel == SEL_TXL || rdec.sel == SEL_TXR);
			d.rdata = '0;
			if (rdec.hit) begin
				unique case (rdec.sel)
					SEL_TXL: d.rdata = {24'h000000, q.vol_left[rdec.path]};
					SEL_TXR: d.rdata = {24'h000000, q.vol_right[rdec.path]};
					SEL_WID: d.rdata = {16'h0000, q.width[rdec.path]};
					SEL_EQ1: d.rdata = {16'h0000, q.eq_first[rdec.path]};
					SEL_EQ2: d.rdata = {16'h0000, q.eq_second[rdec.path]};
					SEL_COEF: d.rdata = {16'h0000, q.coef[rdec.path][rdec.cidx]};
					default: d.rdata = {31'h00000000, q.mode[rdec.path]};
				endcase
			end
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.awready <= 1'b1;
			q.wready <= 1'b1;
			q.arready <= 1'b1;
			q.eq_first <= {2{dpe_pkg::EQ_FIRST_RST}};
			q.eq_second <= {2{dpe_pkg::EQ_SECOND_RST}};
			q.vol_left <= {2{dpe_pkg::VOL_RST}};
			q.vol_right <= {2{dpe_pkg::VOL_RST}};
			q.app_left <= {2{dpe_pkg::VOL_RST}};
			q.app_right <= {2{dpe_pkg::VOL_RST}};
		end else begin
			q <= d;
		end
	end

	assign awready = q.awready;
	assign wready = q.wready;
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign arready = q.arready;
	assign rvalid = q.rvalid;
	assign rresp = q.rresp;
	assign rdata = q.rdata;
	assign rx_out_valid = q.rx_valid;
	assign rx_out_left = q.rx_left;
	assign rx_out_right = q.rx_right;
	assign tx_out_valid = q.tx_valid;
	assign tx_out_left = q.tx_left;
	assign tx_out_right = q.tx_right;

	// ==========================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_gain_reset: assert property ($rose(aresetn) |-> q.eq_first[0][15:1] == 15'h318c &&
		q.eq_second[1][15:6] == 10'h18c) else $error("band gains not 0 dB after reset");
	a_vol_reset: assert property ($rose(aresetn) |-> q.vol_left == 16'hc0c0 &&
		!q.eq_first[0][0] && !q.width[1][8]) else $error("volume or enables wrong after reset");
	a_store_only: assert property (tx_in_valid[0] && !q.pending[0] |=>
		$stable(q.app_left[0]) && $stable(q.app_right[0]))
		else $error("volume applied without update bit");
	a_commit_apply: assert property (q.pending[0] && tx_in_valid[0] |=>
		q.app_left[0] == $past(q.vol_left[0]) && q.app_right[0] == $past(q.vol_right[0]))
		else $error("left and right gains not applied together");
	a_commit_reads0: assert property (q.rvalid && q.rd_vol |-> q.rdata[31:8] == 24'h000000)
		else $error("update bit read back non-zero");
	a_mute_code: assert property (tx_in_valid[1] && !q.pending[1] && q.app_left[1] == 8'h00
		|=> tx_out_left[1] == 16'h0000) else $error("zero code did not mute");
	a_unity_vol: assert property (tx_in_valid[0] && !q.pending[0] && q.app_right[0] == 8'hc0
		|=> tx_out_right[0] == $past(tx_in_right[0])) else $error("0 dB volume not transparent");
	a_eq_bypass: assert property (rx_in_valid[0] && !q.eq_first[0][0] &&
		q.width[0][13:9] == 5'h00 ##1 1'b1 |-> rx_out_left[0] == $past(rx_in_left[0]))
		else $error("disabled equaliser altered samples");
	a_flat_bands: assert property (rx_in_valid[1] && q.eq_first[1] == 16'h6319 &&
		q.eq_second[1] == 16'h6300 && !q.width[1][8] |=> rx_out_right[1] == $past(rx_in_right[1]))
		else $error("0 dB bands not transparent");
	a_bresp_after: assert property (q.aw_held && q.w_held && !q.bvalid |=> q.bvalid [*1] ##0
		(q.bresp == RESP_OKAY || q.bresp == RESP_SLVERR)) else $error("write got no response");

	c_commit_sample: cover property (q.pending[0] ##1 tx_in_valid[0] ##1 tx_out_valid[0]);
	c_user_mode: cover property (q.mode[1] && q.eq_first[1][0] && rx_in_valid[1]);
	c_width_on: cover property (q.width[0][8] && q.width[0][13:9] == 5'h1f && rx_in_valid[0]);
	c_unmapped: cover property (q.rvalid && q.rresp == RESP_SLVERR);

endmodule

// >>> dpe_audio_model.sv
// Audio interface model: sends stereo samples into the playback and record inputs.
// Assumes the block's clock; data lines scramble between strobes.
module dpe_audio_model (
	// Clock
	input wire logic aclk,
	// Samples towards the block
	output logic [1:0] rxv,
	output logic [1:0][15:0] rxl,
	output logic [1:0][15:0] rxr,
	output logic [1:0] txv,
	output logic [1:0][15:0] txl,
	output logic [1:0][15:0] txr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rxv = '0;
		txv = '0;
		rxl = '0;
		rxr = '0;
		txl = '0;
		txr = '0;
	end
	// One strobe carries left and right together; there is no back-pressure
	task automatic send(input bit tx, input int p, input logic [15:0] l, input logic [15:0] r);
		@(posedge aclk);
		if (tx) begin
			txv[p] <= 1'b1;
			txl[p] <= l;
			txr[p] <= r;
		end else begin
			rxv[p] <= 1'b1;
			rxl[p] <= l;
			rxr[p] <= r;
		end
		@(posedge aclk);
		rxv <= '0;
		txv <= '0;
		// Stale data is never trusted: lines invert once the strobe is gone
		rxl[p] <= ~l;
		rxr[p] <= ~r;
		txl[p] <= ~l;
		txr[p] <= ~r;
	endtask
endmodule

// >>> tb_top.sv
// Self-checking bench: registers over AXI4-Lite, samples through the audio model.
// Assumes the block answers every request; each wait is bounded.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [15:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp, rxv, txv, rxov, txov;
	logic [1:0][15:0] rxl, rxr, txl, txr, rxol, rxor, txol, txor;
	int err_count = 0;
	int checks = 0;
	dpe_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .rx_in_valid(rxv), .rx_in_left(rxl),
		.rx_in_right(rxr), .rx_out_valid(rxov), .rx_out_left(rxol), .rx_out_right(rxor),
		.tx_in_valid(txv), .tx_in_left(txl), .tx_in_right(txr), .tx_out_valid(txov),
		.tx_out_left(txol), .tx_out_right(txor));
	dpe_audio_model pm (.aclk(aclk), .rxv(rxv), .rxl(rxl), .rxr(rxr), .txv(txv), .txl(txl),
		.txr(txr));
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, e, s);
		end
	endtask
	// Bounded wait: running out counts as a mismatch and ends the run
	task automatic tick(inout int k);
		@(posedge aclk);
		k++;
		if (k > 60) begin
			err_count++;
			wrap_up();
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
		int k = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			tick(k);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		while (bvalid !== 1'b1) tick(k);
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
		int k = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do tick(k); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) tick(k);
		rready <= 1'b0;
		chk("rdata", e, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask
	// Sends one stereo sample and compares the processed pair one clock later
	task automatic smp(input bit tx, input int p, input logic [15:0] l, input logic [15:0] r,
		input logic [15:0] el, input logic [15:0] er);
		pm.send(tx, p, l, r);
		#1;
		chk("out_valid", 1, tx ? txov[p] : rxov[p]);
		chk("out_left", el, tx ? txol[p] : rxol[p]);
		chk("out_right", er, tx ? txor[p] : rxor[p]);
	endtask
	task automatic t_regs();
		rd(16'h1200, 32'h6318, 2'h0);
		rd(16'h1604, 32'h6300, 2'h0);
		rd(16'h1484, 32'h0, 2'h0);
		rd(16'h1000, 32'hc0, 2'h0);
		rd(16'h0ffc, 32'h0, 2'h2);
		wr(16'h0ffc, 32'hffff, 2'h2);
		wr(16'h1084, 32'hffff, 2'h0);
		rd(16'h1084, 32'h3f00, 2'h0);
		wr(16'h1204, 32'hffff, 2'h0);
		rd(16'h1204, 32'hffc0, 2'h0);
		$display("test regs done");
	endtask
	task automatic t_rx();
		wr(16'h1084, 32'h0, 2'h0);
		smp(0, 0, 16'h1234, 16'hf00d, 16'h1234, 16'hf00d);
		wr(16'h1204, 32'h6300, 2'h0);
		wr(16'h1200, 32'h6319, 2'h0);
		smp(0, 0, 16'h0800, 16'h0400, 16'h0800, 16'h0400);
		wr(16'h1084, 32'h0100, 2'h0);
		smp(0, 0, 16'h0800, 16'h0400, 16'h0800, 16'h0400);
		wr(16'h1084, 32'h3f00, 2'h0);
		smp(0, 0, 16'h0100, 16'h0000, 16'h04bd, 16'hfc43);
		@(posedge aclk);
		#1;
		chk("out_valid_pulse", 0, rxov[0]);
		smp(0, 1, 16'hff00, 16'h00ff, 16'hff00, 16'h00ff);
		$display("test rx done");
	endtask
	task automatic t_vol();
		smp(1, 0, 16'h1000, 16'h1000, 16'h1000, 16'h1000);
		wr(16'h1000, 32'h0, 2'h0);
		smp(1, 0, 16'h1000, 16'h1000, 16'h1000, 16'h1000);
		rd(16'h1000, 32'h0, 2'h0);
		wr(16'h1004, 32'h01c0, 2'h0);
		rd(16'h1004, 32'hc0, 2'h0);
		smp(1, 0, 16'h1000, 16'h1000, 16'h0, 16'h1000);
		wr(16'h1400, 32'h0100, 2'h0);
		smp(1, 1, 16'h2000, 16'h2000, 16'h0, 16'h2000);
		smp(1, 1, 16'h2000, 16'h2000, 16'h0, 16'h2000);
		wr(16'h1000, 32'hff, 2'h0);
		wr(16'h1004, 32'h01ef, 2'h0);
		smp(1, 0, 16'h0100, 16'h0100, 16'h07a4, 16'h07a4);
		wr(16'h1000, 32'h01b0, 2'h0);
		smp(1, 0, 16'h1000, 16'h1000, 16'h0800, 16'h7a4e);
		$display("test vol done");
	endtask
	// Writes and reads back the last user coefficient, reads the slot past it as an error, then switches path two to user mode
	task automatic t_user();
		wr(16'h164c, 32'hbeef, 2'h0);
		rd(16'h164c, 32'hbeef, 2'h0);
		rd(16'h1650, 32'h0, 2'h2);
		wr(16'h1680, 32'h0001, 2'h0);
		rd(16'h1680, 32'h1, 2'h0);
		wr(16'h1600, 32'h6319, 2'h0);
		smp(0, 1, 16'h4000, 16'hc000, 16'h4000, 16'hc000);
		$display("test user done");
	endtask
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		aresetn = 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_rx();
		t_vol();
		t_user();
		wrap_up();
	end
endmodule
